// [hdl/pss_pkg.sv]
/*
  Package for the correction-stage supply sequencer: timing constants,
  register offsets, field positions, state encoding and carrier structs.
  Assumes a 40 MHz hclk and an AHB-Lite register bus.
*/
package pss_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STBY_QUAL_MS = 90;
  localparam int unsigned STBY_QUAL_CYC = STBY_QUAL_MS * (CLK_HZ / 1000);
  localparam int unsigned FAULT_DLY_MS = 10;
  localparam int unsigned FAULT_DLY_CYC = FAULT_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------
  // comparator references, millivolts
  // ----------------------------------------
  localparam logic [9:0] STBY_REF_MV = 10'd250;
  localparam logic [9:0] BO_REF_HI_MV = 10'd500;
  localparam logic [9:0] BO_REF_LO_MV = 10'd250;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_LEVELS = 8'h10;

  localparam int CTRL_ENABLE = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // status field positions
  localparam int ST_SWITCH = 0;
  localparam int ST_PULSE = 1;
  localparam int ST_STBY_REQ = 2;
  localparam int ST_BROWNOUT = 3;
  localparam int ST_QUAL_RUN = 4;
  localparam int ST_STATE_LSB = 8;

  // irq bit positions
  localparam int IRQ_W = 5;
  localparam int IRQ_STBY_CONF = 0;
  localparam int IRQ_STBY_EXIT = 1;
  localparam int IRQ_SHORT = 2;
  localparam int IRQ_UVLO = 3;
  localparam int IRQ_BROWNOUT = 4;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_STARTUP = 3'b001,
    ST_RUN     = 3'b010,
    ST_STANDBY = 3'b011,
    ST_HICCUP  = 3'b100
  } pss_state_e;

  // analog-side sense inputs, all asynchronous levels
  typedef struct packed {
    logic standby_cmp;
    logic bulk_ok;
    logic peak_limit_flag;
    logic short_circuit;
    logic supply_undervoltage;
  } pss_sense_s;

endpackage

// [hdl/pss_sequencer.sv]
/*
  Correction-stage supply sequencer: drives the supply switch of the
  front-end correction stage from standby, peak-limit and fault levels, and
  gates driver pulses from brown-out, short-circuit and undervoltage sense levels.
  Assumes the sense inputs come from comparators outside this clock
  domain and that software is an AHB-Lite master on hclk.
*/
// Local design decisions: the AHB-Lite register port and the placing of the registers.
// Operation
// R01: standby asserted when sense below 250 mV
// R02: qualification timer starts on standby rise
// R03: timer expiry with standby confirms, opens switch
// R04: standby fall closes switch at once
// R05: switch open during startup
// R06: startup closes switch when peak flag drops
// R07: switch never closes in short-circuit hiccup
// R08: short-circuit delay, then stop pulses, hiccup
// R09: undervoltage stops pulses, removes supply immediately
// R10: brown-out stops pulses, switch open throughout
// R11: brown-out reference drops 500 to 250 mV
// R12: brown-out not latched, pulses resume
// R13: after brown-out, clean startup before closing
// R14: early standby fall abandons timer, switch stays
`timescale 1ns/1ps

module pss_sequencer #(
  parameter int unsigned STBY_QUAL_CYC = pss_pkg::STBY_QUAL_CYC, // qualification count
  parameter int unsigned FAULT_DLY_CYC = pss_pkg::FAULT_DLY_CYC  // short-circuit delay
) (
  input wire logic hclk, // 40 MHz clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire pss_pkg::pss_sense_s sense, // comparator levels
  output logic correction_supply_switch, // switch closed when high
  output logic pulse_enable, // driver pulses allowed
  output logic bo_ref_low, // brown-out ref at 250 mV
  output logic irq // level interrupt
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  pss_pkg::pss_sense_s sync1;
  pss_pkg::pss_sense_s sync2;

  // two stages; only sync2 is looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= sense;
      sync2 <= sync1;
    end
  end

  logic standby_request;
  logic brownout_detect;
  logic peak_limit_flag;
  logic supply_undervoltage;
  logic short_circuit;

  // standby comparator reads high when load level is below its reference; bulk_ok reads high when bulk is ok
  assign standby_request = sync2.standby_cmp; // R01
  assign brownout_detect = ~sync2.bulk_ok; // R12
  assign peak_limit_flag = sync2.peak_limit_flag;
  assign supply_undervoltage = sync2.supply_undervoltage;
  assign short_circuit = sync2.short_circuit;

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [pss_pkg::IRQ_W-1:0] irq_stat;
  logic [pss_pkg::IRQ_W-1:0] irq_mask;
  logic [pss_pkg::IRQ_W-1:0] irq_evt;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic enable;

  assign enable = ctrl[pss_pkg::CTRL_ENABLE];

  // write decode shared by every writable register
  function automatic logic reg_write_hit(input logic valid, input logic wr,
                                         input logic [7:0] a, input logic [7:0] target);
    return valid && wr && (a == target);
  endfunction

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  pss_pkg::pss_state_e state;
  pss_pkg::pss_state_e next_state;
  logic [pss_pkg::CNT_W-1:0] qual_cnt;
  logic [pss_pkg::CNT_W-1:0] fault_cnt;
  logic qual_run;
  logic stby_prev;
  logic stby_rise;
  logic qual_done;
  logic fault_done;
  logic hard_stop;

  assign stby_rise = standby_request & ~stby_prev; // R02
  assign qual_done = qual_run && (qual_cnt == pss_pkg::CNT_W'(STBY_QUAL_CYC - 1));
  assign fault_done = short_circuit && (fault_cnt == pss_pkg::CNT_W'(FAULT_DLY_CYC - 1));
  // undervoltage and brown-out act with no fault delay counter, only the synchroniser latency
  // enable low forces the same safe state as a hard fault
  assign hard_stop = supply_undervoltage | brownout_detect | ~enable; // R09 R10

  // standby edge tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stby_prev <= 1'b0;
    end else begin
      stby_prev <= standby_request;
    end
  end

  // qualification timer; restarts on every rise, dies on fall
  // a standby level already present on entry to run needs a fresh rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_run <= 1'b0;
      qual_cnt <= '0;
    end else if (state != pss_pkg::ST_RUN || !standby_request) begin
      qual_run <= 1'b0; // R14
      qual_cnt <= '0;
    end else if (stby_rise) begin
      qual_run <= 1'b1; // R02
      qual_cnt <= '0;
    end else if (qual_done) begin
      qual_run <= 1'b0;
      qual_cnt <= '0;
    end else if (qual_run) begin
      qual_cnt <= qual_cnt + 1'b1;
    end
  end

  // short-circuit fault delay counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_cnt <= '0;
    end else if (!short_circuit || state == pss_pkg::ST_HICCUP || hard_stop) begin
      fault_cnt <= '0;
    end else if (!fault_done) begin
      fault_cnt <= fault_cnt + 1'b1; // R08
    end
  end

  // next-state decision; hard stops take priority
  always_comb begin
    next_state = state;
    if (hard_stop) begin
      next_state = pss_pkg::ST_OFF; // R09 R10
    end else begin
      case (state)
        pss_pkg::ST_OFF: begin
          next_state = pss_pkg::ST_STARTUP; // R13
        end
        pss_pkg::ST_STARTUP: begin
          if (fault_done) begin
            next_state = pss_pkg::ST_HICCUP;
          end else if (!peak_limit_flag) begin
            next_state = pss_pkg::ST_RUN; // R06
          end
        end
        pss_pkg::ST_RUN: begin
          if (fault_done) begin
            next_state = pss_pkg::ST_HICCUP; // R08
          end else if (qual_done) begin
            next_state = pss_pkg::ST_STANDBY; // R03
          end
        end
        pss_pkg::ST_STANDBY: begin
          if (fault_done) begin
            next_state = pss_pkg::ST_HICCUP;
          end else if (!standby_request) begin
            next_state = pss_pkg::ST_RUN; // R04
          end
        end
        pss_pkg::ST_HICCUP: begin
          // restart attempt only once the short is gone
          if (!short_circuit) begin
            next_state = pss_pkg::ST_STARTUP; // R07
          end
        end
        default: begin
          next_state = pss_pkg::ST_OFF;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= pss_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // outputs; switch only closed in run, so hiccup and startup keep it open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      correction_supply_switch <= 1'b0;
      pulse_enable <= 1'b0;
    end else begin
      correction_supply_switch <= (next_state == pss_pkg::ST_RUN); // R05 R06 R07 R13
      pulse_enable <= (next_state == pss_pkg::ST_STARTUP) ||
                      (next_state == pss_pkg::ST_RUN) ||
                      (next_state == pss_pkg::ST_STANDBY); // R08 R12
    end
  end

  // brown-out hysteresis: lower reference once bulk is ok
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bo_ref_low <= 1'b0;
    end else begin
      bo_ref_low <= ~brownout_detect; // R11
    end
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  always_comb begin
    irq_evt = '0;
    irq_evt[pss_pkg::IRQ_STBY_CONF] = (state == pss_pkg::ST_RUN) &&
                                      (next_state == pss_pkg::ST_STANDBY);
    irq_evt[pss_pkg::IRQ_STBY_EXIT] = (state == pss_pkg::ST_STANDBY) &&
                                      (next_state == pss_pkg::ST_RUN);
    irq_evt[pss_pkg::IRQ_SHORT] = fault_done && (state != pss_pkg::ST_HICCUP) && !hard_stop;
    irq_evt[pss_pkg::IRQ_UVLO] = supply_undervoltage && (state != pss_pkg::ST_OFF);
    irq_evt[pss_pkg::IRQ_BROWNOUT] = brownout_detect && (state != pss_pkg::ST_OFF);
  end

  // ----------------------------------------
  // status image
  // ----------------------------------------
  logic [31:0] status_word;

  // built from named field positions so the map lives in one place
  always_comb begin
    status_word = '0;
    status_word[pss_pkg::ST_SWITCH] = correction_supply_switch;
    status_word[pss_pkg::ST_PULSE] = pulse_enable;
    status_word[pss_pkg::ST_STBY_REQ] = standby_request;
    status_word[pss_pkg::ST_BROWNOUT] = brownout_detect;
    status_word[pss_pkg::ST_QUAL_RUN] = qual_run;
    status_word[pss_pkg::ST_STATE_LSB +: $bits(pss_pkg::pss_state_e)] = state;
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= '0;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // hsize is not decoded: software must use whole-word transfers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= pss_pkg::CTRL_RST;
    end else if (reg_write_hit(ph_valid, ph_write, ph_addr, pss_pkg::ADDR_CTRL)) begin
      ctrl <= {31'h0000_0000, hwdata[pss_pkg::CTRL_ENABLE]};
    end
  end

  // mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (reg_write_hit(ph_valid, ph_write, ph_addr, pss_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= hwdata[pss_pkg::IRQ_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else if (reg_write_hit(ph_valid, ph_write, ph_addr, pss_pkg::ADDR_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~hwdata[pss_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // read mux, registered in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        pss_pkg::ADDR_CTRL: begin
          hrdata <= ctrl;
        end
        pss_pkg::ADDR_STATUS: begin
          hrdata <= status_word;
        end
        pss_pkg::ADDR_IRQ_STAT: begin
          hrdata <= {27'h0000000, irq_stat};
        end
        pss_pkg::ADDR_IRQ_MASK: begin
          hrdata <= {27'h0000000, irq_mask};
        end
        pss_pkg::ADDR_LEVELS: begin
          hrdata <= {6'h00, bo_ref_low ? pss_pkg::BO_REF_LO_MV : pss_pkg::BO_REF_HI_MV,
                     6'h00, pss_pkg::STBY_REF_MV};
        end
        default: begin
          hrdata <= '0;
        end
      endcase
    end
  end

endmodule

// [sim/pss_pfc_model.sv]
/*
  Behavioural model of the correction-stage supply rail fed by the switch.
  Assumes the switch level is registered on hclk by the sequencer.
*/
`timescale 1ns/1ps
module pss_pfc_model (
  input wire logic hclk, // system clock
  input wire logic supply_in, // switch closed when high
  output logic powered // stage supplied
);
  // rail settles one cycle behind the switch, never ahead of it
  always_ff @(posedge hclk) begin
    powered <= supply_in;
  end
endmodule

// [sim/pss_seq_properties.sv]
/*
  Checker for the supply sequencer, bound to its top ports.
  Assumes sense levels stay put for several cycles between steps.
*/
`timescale 1ns/1ps
module pss_seq_props #(
  parameter int unsigned STBY_QUAL_CYC = 20, // qualification count
  parameter int unsigned FAULT_DLY_CYC = 10 // short-circuit delay
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire pss_pkg::pss_sense_s sense, // comparator levels
  input wire logic correction_supply_switch, // switch closed
  input wire logic pulse_enable, // pulses allowed
  input wire logic bo_ref_low // brown-out ref low
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // pin-level hold counters
  // ----------------------------------------
  logic [31:0] stby_held;
  logic [31:0] short_held;
  // cycles standby has stood at the pin; saturates rather than wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stby_held <= '0;
    end else if (!sense.standby_cmp) begin
      stby_held <= '0;
    end else if (stby_held != 32'hFFFF_FFFF) begin
      stby_held <= stby_held + 32'h0000_0001;
    end
  end
  // cycles the short has stood at the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_held <= '0;
    end else if (!sense.short_circuit) begin
      short_held <= '0;
    end else if (short_held != 32'hFFFF_FFFF) begin
      short_held <= short_held + 32'h0000_0001;
    end
  end
  stby_min_a: assert property ($fell(correction_supply_switch) && pulse_enable |->
    stby_held >= STBY_QUAL_CYC) else $error("standby confirmed early");
  short_min_a: assert property ($fell(pulse_enable) && sense.short_circuit |->
    short_held >= FAULT_DLY_CYC) else $error("fault delay too short");
  // ----------------------------------------
  // hard stops, allowing sync plus output latency
  // ----------------------------------------
  uv_stop_a: assert property (sense.supply_undervoltage [*5] |->
    !pulse_enable && !correction_supply_switch) else $error("pulses under undervoltage");
  bo_stop_a: assert property (!sense.bulk_ok [*5] |->
    !pulse_enable && !correction_supply_switch && !bo_ref_low) else $error("brown-out ignored");
  bo_ref_hi_a: assert property (sense.bulk_ok [*5] |-> bo_ref_low)
    else $error("reference not lowered");
  // ----------------------------------------
  // switch sequencing
  // ----------------------------------------
  run_close_a: assert property ((!sense.standby_cmp && !sense.peak_limit_flag &&
    sense.bulk_ok && !sense.supply_undervoltage && !sense.short_circuit) [*8] |->
    correction_supply_switch) else $error("switch not closed");
  sw_pulse_a: assert property (!pulse_enable |-> !correction_supply_switch)
    else $error("switch closed without pulses");
  start_open_a: assert property ($rose(pulse_enable) |-> !correction_supply_switch)
    else $error("switch closed at startup");
  stby_qual_a: assert property ($fell(correction_supply_switch) && pulse_enable |->
    $past(sense.standby_cmp, 8)) else $error("standby not qualified");
  short_wait_a: assert property ($fell(pulse_enable) && sense.short_circuit |->
    $past(sense.short_circuit, 8)) else $error("fault delay skipped");
endmodule

// [sim/pss_sequencer_bench.sv]
/*
  Self-checking bench for the supply sequencer with short counts.
  Assumes zero-wait AHB-Lite slave and 3-edge sense latency.
*/
`timescale 1ns/1ps
module pss_sequencer_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sw, pulse, ref_low, irq, powered;
  logic [31:0] hrdata, rd;
  pss_pkg::pss_sense_s sense = 5'h0C;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 hclk = ~hclk;
  pss_sequencer #(.STBY_QUAL_CYC(20), .FAULT_DLY_CYC(10)) i_pss_sequencer (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sense(sense), .correction_supply_switch(sw), .pulse_enable(pulse),
    .bo_ref_low(ref_low), .irq(irq));
  pss_pfc_model i_pss_pfc_model (.hclk(hclk), .supply_in(sw), .powered(powered));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single transfer; read data taken at the data-phase edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_start;
    tick(5);
    chk(pulse, 1);
    chk(sw, 0);
    xfer(0, 8'h10, 0);
    chk(rd, 32'h00FA_00FA);
    xfer(1, 8'h00, 0);
    tick(2);
    chk({pulse, sw}, 0);
    xfer(0, 8'h00, 0);
    chk(rd, 0);
    xfer(1, 8'h00, 1);
    tick(2);
    chk({pulse, sw}, 2'b10);
    sense.peak_limit_flag <= 1'b0;
    tick(6);
    chk(powered, 1);
    $display("startup done");
  endtask
  task t_stby;
    sense.standby_cmp <= 1'b1;
    tick(10);
    sense.standby_cmp <= 1'b0;
    tick(3);
    chk(sw, 1);
    sense.standby_cmp <= 1'b1;
    tick(15);
    chk(sw, 1);
    tick(12);
    chk(sw, 0);
    xfer(1, 8'h0C, 1);
    xfer(0, 8'h08, 0);
    chk(irq, 1);
    sense.standby_cmp <= 1'b0;
    tick(4);
    chk(sw, 1);
    xfer(1, 8'h08, 1);
    xfer(0, 8'h08, 0);
    chk(rd, 2);
    chk(irq, 0);
    $display("standby done");
  endtask
  task t_short;
    sense.short_circuit <= 1'b1;
    sense.peak_limit_flag <= 1'b1;
    tick(6);
    chk(pulse, 1);
    tick(12);
    chk(pulse | sw, 0);
    sense.short_circuit <= 1'b0;
    tick(6);
    chk({pulse, sw}, 2'b10);
    sense.peak_limit_flag <= 1'b0;
    tick(6);
    chk(sw, 1);
    $display("short done");
  endtask
  task t_uv;
    sense.supply_undervoltage <= 1'b1;
    tick(4);
    chk(pulse | sw, 0);
    tick(4);
    chk(pulse | sw, 0);
    sense.supply_undervoltage <= 1'b0;
    tick(10);
    chk(sw, 1);
    $display("undervoltage done");
  endtask
  task t_bo;
    sense.bulk_ok <= 1'b0;
    tick(4);
    chk({pulse, sw, ref_low}, 0);
    tick(20);
    xfer(0, 8'h10, 0);
    chk(rd, 32'h01F4_00FA);
    chk(sw, 0);
    xfer(0, 8'h40, 0);
    chk(rd, 0);
    sense.bulk_ok <= 1'b1;
    sense.peak_limit_flag <= 1'b1;
    tick(6);
    chk({pulse, sw}, 2'b10);
    sense.peak_limit_flag <= 1'b0;
    tick(6);
    chk(sw, 1);
    xfer(0, 8'h08, 0);
    chk(rd, 32'h0000_001E);
    $display("brown-out done");
  endtask
  // hang guard, far above the 167 cycles needed
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    tick(2);
    hresetn <= 1'b1;
    t_start;
    t_stby;
    t_short;
    t_uv;
    t_bo;
    stop_test;
  end
endmodule
bind pss_sequencer pss_seq_props #(.STBY_QUAL_CYC(STBY_QUAL_CYC),
  .FAULT_DLY_CYC(FAULT_DLY_CYC)) i_pss_seq_props (.hclk(hclk), .hresetn(hresetn),
  .sense(sense), .correction_supply_switch(correction_supply_switch),
  .pulse_enable(pulse_enable), .bo_ref_low(bo_ref_low));
